//--- shared/io_port_pkg.sv
// Package with register map, reset values and carrier types of the I/O port block
package io_port_pkg;
  // Port slots: 0..5 stand for ports 7, 8, 9, A, B and C
  localparam int NUM_PORTS = 6;
  localparam logic [2:0] SLOT_P8 = 3'h1;
  localparam logic [2:0] SLOT_PB = 3'h4;
  localparam logic [2:0] SLOT_PC = 3'h5;
  typedef logic [NUM_PORTS-1:0][7:0] port_bits_t;

  // Register word index = {bank, offset}; byte address = 4 * index
  localparam logic [3:0] BANK_DATA = 4'h0;
  localparam logic [3:0] BANK_DIR = 4'h4;
  localparam logic [3:0] BANK_PULL = 4'h5;
  localparam logic [3:0] BANK_DRAIN = 4'h6;
  localparam logic [3:0] BANK_EVENT = 4'h7;
  localparam logic [3:0] IDX_PORT7 = 4'h7;
  localparam logic [3:0] IDX_PORTB = 4'hB;
  localparam logic [3:0] IDX_PORTC = 4'hC;
  localparam logic [3:0] IDX_STATUS = 4'h0;
  localparam logic [3:0] IDX_MASK = 4'h1;

  // Implemented bits and bits that read back as ones
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_P8 = 8'hFE;
  localparam logic [7:0] MASK_PC = 8'h0F;
  localparam logic [7:0] ONES_PC = 8'hF0;

  // Values after reset: every pin an input, latches high, pull-ups and drains off
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_DRAIN = 8'h00;

  // Pins watched for input change and their place in the status register
  localparam logic [7:0] WATCH_P7 = 8'hF0;
  localparam logic [7:0] WATCH_P8 = 8'h0C;
  localparam logic [7:0] WATCH_PB = 8'h0F;
  localparam int EVT_WIDTH = 10;
  localparam logic [EVT_WIDTH-1:0] RST_EVT = 10'h000;

  // Drive towards the pads
  typedef struct packed {
    port_bits_t out;
    port_bits_t oe;
    port_bits_t pullEn;
  } pad_drive_s;
endpackage : io_port_pkg

//--- core/io_port_pad_config.sv
// I/O port configuration, data and input-change logic behind an APB slave
// Operation
// - Port C pull-up register: bits 3..0 enable pull-ups, upper bits read zero
// - Ports 7, 9, A, B: eight open-drain enables, 1 open-drain, 0 push-pull
// - Port 8 open-drain register implements bits 7..1; bit 0 reads zero
// - Port C data register holds bits 3..0; upper bits read as ones
// - Every pin is tri-state; driver released whenever pin is not an output
// - Each pin's pull-up switches only by its software control bit
// - Each pin except port C's and port 8 bit 0 can be put into open-drain output by software
// - Changes on port 7[7:4], port B[3:0], port 8[3:2] raise events
// - Per-pin direction bits in bank 4 offsets 0x07 through 0x0C
// - Data and direction registers are both readable and writable; a data read returns the pin level, not the latch, for input pins
// - Direction bit 0 makes the pin an output, 1 an input
// - Ports 7, 9, A, B pull-up registers hold eight enables
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
module io_port_pad_config (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads
  input wire io_port_pkg::port_bits_t pinIn,
  output io_port_pkg::pad_drive_s pad,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    io_port_pkg::port_bits_t dir;
    io_port_pkg::port_bits_t data;
    io_port_pkg::port_bits_t pull;
    io_port_pkg::port_bits_t drain;
    io_port_pkg::port_bits_t pinPrev;
    logic [io_port_pkg::EVT_WIDTH-1:0] status;
    logic [io_port_pkg::EVT_WIDTH-1:0] mask;
    logic [31:0] rdata;
    logic err;
    io_port_pkg::pad_drive_s pad;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [3:0] bank;
  logic [3:0] idx;
  logic [2:0] slot;
  logic slotOk;
  logic setupRd;
  logic wrDone;
  logic rdDone;
  logic [io_port_pkg::EVT_WIDTH-1:0] events;

  // Bits that exist in a port's registers
  function automatic logic [7:0] implMask(input logic [2:0] sl);
    if (sl == io_port_pkg::SLOT_P8) begin
      implMask = io_port_pkg::MASK_P8;
    end else if (sl == io_port_pkg::SLOT_PC) begin
      implMask = io_port_pkg::MASK_PC;
    end else begin
      implMask = io_port_pkg::MASK_FULL;
    end
  endfunction : implMask

  // Reserved bits that read back as ones (port C data and direction)
  function automatic logic [7:0] readOnes(input logic [2:0] sl);
    readOnes = (sl == io_port_pkg::SLOT_PC) ? io_port_pkg::ONES_PC : 8'h00;
  endfunction : readOnes

  // Address split and port slot decode
  assign bank = paddr[9:6];
  assign idx = paddr[5:2];
  assign slot = 3'(idx - io_port_pkg::IDX_PORT7);
  assign slotOk = (idx >= io_port_pkg::IDX_PORT7) && (idx <= io_port_pkg::IDX_PORTC)
                  && (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  assign setupRd = psel && !penable && !pwrite;
  assign wrDone = psel && penable && pwrite;
  assign rdDone = psel && penable && !pwrite;

  // Handshake: zero wait states
  assign pready = 1'b1;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.err;
  assign pad = s_q.pad;
  assign irq = |(s_q.status & s_q.mask);

  // Input-change events on the watched pins
  always_comb begin
    logic [7:0] c7;
    logic [7:0] c8;
    logic [7:0] cb;
    c7 = (pinIn[0] ^ s_q.pinPrev[0]) & io_port_pkg::WATCH_P7;
    c8 = (pinIn[io_port_pkg::SLOT_P8] ^ s_q.pinPrev[io_port_pkg::SLOT_P8])
         & io_port_pkg::WATCH_P8;
    cb = (pinIn[io_port_pkg::SLOT_PB] ^ s_q.pinPrev[io_port_pkg::SLOT_PB])
         & io_port_pkg::WATCH_PB;
    events = {cb[3:0], c8[3:2], c7[7:4]};
  end

  // Next state: register writes, read capture, events and pad drive
  always_comb begin
    logic [7:0] wb;
    logic [7:0] rd;
    logic hit;
    wb = pwdata[7:0];
    rd = 8'h00;
    hit = 1'b0;
    s_d = s_q;
    s_d.pinPrev = pinIn;
    // Writes take effect at the access edge
    if (wrDone && slotOk) begin
      unique case (bank)
        io_port_pkg::BANK_DIR: begin
          s_d.dir[slot] = (wb & implMask(slot)) | ~implMask(slot);
        end
        io_port_pkg::BANK_PULL: begin
          s_d.pull[slot] = wb & implMask(slot);
        end
        io_port_pkg::BANK_DRAIN: begin
          if (slot == io_port_pkg::SLOT_PC) begin
            s_d.data[slot] = wb & implMask(slot);
          end else begin
            s_d.drain[slot] = wb & implMask(slot);
          end
        end
        io_port_pkg::BANK_DATA: begin
          if (slot != io_port_pkg::SLOT_PC) begin
            s_d.data[slot] = wb & implMask(slot);
          end
        end
        default: begin
        end
      endcase
    end
    if (wrDone && paddr[11:6] == {2'b00, io_port_pkg::BANK_EVENT}
        && idx == io_port_pkg::IDX_MASK && paddr[1:0] == 2'b00) begin
      s_d.mask = pwdata[io_port_pkg::EVT_WIDTH-1:0];
    end
    // Status: a read clears only the bits it reported, so an event landing
    // between capture and access is kept; a new event in the clear cycle still wins
    s_d.status = s_q.status;
    if (rdDone && paddr[11:6] == {2'b00, io_port_pkg::BANK_EVENT}
        && idx == io_port_pkg::IDX_STATUS) begin
      s_d.status = s_q.status & ~s_q.rdata[io_port_pkg::EVT_WIDTH-1:0];
    end
    s_d.status = s_d.status | events;
    // Read data is captured in the setup cycle and shown during access
    if (slotOk) begin
      unique case (bank)
        io_port_pkg::BANK_DIR: begin
          rd = (s_q.dir[slot] & implMask(slot)) | readOnes(slot);
          hit = 1'b1;
        end
        io_port_pkg::BANK_PULL: begin
          rd = s_q.pull[slot] & implMask(slot);
          hit = 1'b1;
        end
        io_port_pkg::BANK_DRAIN: begin
          if (slot == io_port_pkg::SLOT_PC) begin
            rd = (((s_q.dir[slot] & pinIn[slot]) | (~s_q.dir[slot] & s_q.data[slot]))
                  & implMask(slot)) | readOnes(slot);
          end else begin
            rd = s_q.drain[slot] & implMask(slot);
          end
          hit = 1'b1;
        end
        io_port_pkg::BANK_DATA: begin
          rd = ((s_q.dir[slot] & pinIn[slot]) | (~s_q.dir[slot] & s_q.data[slot]))
               & implMask(slot);
          hit = (slot != io_port_pkg::SLOT_PC);
        end
        default: begin
        end
      endcase
    end
    // Event registers; read data changes only in a setup cycle and then stands
    if (psel && !penable) begin
      s_d.rdata = {24'h00_0000, rd};
      if (paddr[11:6] == {2'b00, io_port_pkg::BANK_EVENT} && paddr[1:0] == 2'b00) begin
        if (idx == io_port_pkg::IDX_STATUS) begin
          s_d.rdata = 32'(s_q.status);
          hit = 1'b1;
        end else if (idx == io_port_pkg::IDX_MASK) begin
          s_d.rdata = 32'(s_q.mask);
          hit = 1'b1;
        end
      end
      s_d.err = !hit;
      // Refused reads return zero
      if (!pwrite && !hit) begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    // Pad drive follows the registers that are about to be stored
    for (int p = 0; p < io_port_pkg::NUM_PORTS; p++) begin
      s_d.pad.oe[p] = ~s_d.dir[p] & ~(s_d.drain[p] & s_d.data[p]);
      s_d.pad.out[p] = s_d.data[p] & ~s_d.drain[p];
      s_d.pad.pullEn[p] = s_d.pull[p];
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int p = 0; p < io_port_pkg::NUM_PORTS; p++) begin
        s_q.dir[p] <= io_port_pkg::RST_DIR;
        s_q.data[p] <= io_port_pkg::RST_DATA;
        s_q.pull[p] <= io_port_pkg::RST_PULL;
        s_q.drain[p] <= io_port_pkg::RST_DRAIN;
        // Previous level tracks the pins so release shows no false change
        s_q.pinPrev[p] <= pinIn[p];
        s_q.pad.oe[p] <= 8'h00;
        s_q.pad.out[p] <= 8'h00;
        s_q.pad.pullEn[p] <= 8'h00;
      end
      s_q.status <= io_port_pkg::RST_EVT;
      s_q.mask <= io_port_pkg::RST_EVT;
      s_q.rdata <= 32'h0000_0000;
      s_q.err <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Checks
  default clocking cb_main @(posedge clock);
  endclocking
  default disable iff (rst);

  // Setup cycle aimed at one aligned register
  sequence s_setup_at(logic [3:0] b, logic [3:0] i);
    psel && !penable && paddr[9:6] == b && paddr[5:2] == i && paddr[11:10] == 2'b00
    && paddr[1:0] == 2'b00;
  endsequence

  property p_pullc_reserved;
    s_setup_at(io_port_pkg::BANK_PULL, io_port_pkg::IDX_PORTC) ##1 1'b1
      |-> prdata[31:4] == 28'h000_0000;
  endproperty
  a_pullc_reserved: assert property (p_pullc_reserved) else $error("pull C upper not 0");

  property p_datac_ones;
    s_setup_at(io_port_pkg::BANK_DRAIN, io_port_pkg::IDX_PORTC) |=> prdata[7:4] == 4'hF;
  endproperty
  a_datac_ones: assert property (p_datac_ones) else $error("port C data upper not 1");

  property p_drain8_bit0;
    s_setup_at(io_port_pkg::BANK_DRAIN, 4'h8) |=> prdata[0] == 1'b0;
  endproperty
  a_drain8_bit0: assert property (p_drain8_bit0) else $error("drain 8 bit 0 set");

  property p_input_released;
    wrDone && slotOk && bank == io_port_pkg::BANK_DIR && pwdata[0]
      |=> pad.oe[$past(slot)][0] == 1'b0;
  endproperty
  a_input_released: assert property (p_input_released) else $error("input pin driven");

  property p_drain_release;
    (s_q.drain[0][0] && s_q.data[0][0]) |-> !pad.oe[0][0];
  endproperty
  a_drain_release: assert property (p_drain_release) else $error("drain high driven");

  property p_pushpull_low;
    wrDone && slotOk && bank == io_port_pkg::BANK_DIR && slot == 3'h2 && !pwdata[1]
      && !s_q.drain[2][1] ##1 !s_q.drain[2][1] |-> pad.oe[2][1] && pad.out[2][1] == s_q.data[2][1];
  endproperty
  a_pushpull_low: assert property (p_pushpull_low) else $error("output not driven");

  property p_pull_follow;
    wrDone && slotOk && bank == io_port_pkg::BANK_PULL |=> pad.pullEn[$past(slot)]
      == ($past(pwdata[7:0]) & implMask($past(slot)));
  endproperty
  a_pull_follow: assert property (p_pull_follow) else $error("pull-up mismatch");

  property p_change_sets;
    $changed(pinIn[0][7]) |=> s_q.status[3];
  endproperty
  a_change_sets: assert property (p_change_sets) else $error("change event lost");

  // Clearing the whole mask silences the interrupt on the next cycle
  property p_irq_level;
    wrDone && paddr[11:6] == {2'b00, io_port_pkg::BANK_EVENT}
      && idx == io_port_pkg::IDX_MASK && paddr[1:0] == 2'b00
      && pwdata[io_port_pkg::EVT_WIDTH-1:0] == '0 |=> !irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq with mask clear");

  // Bits that a status read did not report survive its clear
  property p_status_keep;
    rdDone && paddr[11:6] == {2'b00, io_port_pkg::BANK_EVENT}
      && idx == io_port_pkg::IDX_STATUS
      |=> ($past(s_q.status) & ~$past(prdata[io_port_pkg::EVT_WIDTH-1:0]) & ~s_q.status) == '0;
  endproperty
  a_status_keep: assert property (p_status_keep) else $error("unreported event lost");

  property p_dir_write;
    wrDone && slotOk && bank == io_port_pkg::BANK_DIR |=> s_q.dir[$past(slot)]
      == (($past(pwdata[7:0]) & implMask($past(slot))) | ~implMask($past(slot)));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not stored");
endmodule : io_port_pad_config

//--- bench/board_model.sv
// Board model: external drivers, pull-ups and floating pins
`timescale 1ns/1ns
module board_model (
  // Clock
  input wire logic clock,
  // Drive from the device and from the board
  input wire io_port_pkg::pad_drive_s pad,
  input wire io_port_pkg::port_bits_t extEn,
  input wire io_port_pkg::port_bits_t extVal,
  // Levels seen by the device
  output io_port_pkg::port_bits_t pinIn
);
  logic floatPat_q = 1'b0;
  // Undriven pins wander so a stale level is never trusted
  always @(posedge clock) begin
    floatPat_q <= ~floatPat_q;
  end
  // Device driver first, then board driver, then pull-up, else floating
  always_comb begin
    for (int s = 0; s < io_port_pkg::NUM_PORTS; s++) begin
      for (int b = 0; b < 8; b++) begin
        if (pad.oe[s][b]) begin
          pinIn[s][b] = pad.out[s][b];
        end else if (extEn[s][b]) begin
          pinIn[s][b] = extVal[s][b];
        end else if (pad.pullEn[s][b]) begin
          pinIn[s][b] = 1'b1;
        end else begin
          pinIn[s][b] = floatPat_q ^ b[0];
        end
      end
    end
  end
endmodule : board_model

//--- bench/test_io_port_pad_config.sv
// Testbench for the I/O port block over APB with a board model
`timescale 1ns/1ns
module test_io_port_pad_config;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] rd;
  logic err;
  io_port_pkg::port_bits_t pinIn;
  io_port_pkg::port_bits_t extEn = 48'hFFFF_FFFF_FFFF;
  io_port_pkg::port_bits_t extVal = 48'hFFFF_FFFF_FFFF;
  io_port_pkg::pad_drive_s pad;
  int checked = 0;
  int mismatches = 0;
  int s;
  int b;
  localparam logic [7:0] STAT = {io_port_pkg::BANK_EVENT, io_port_pkg::IDX_STATUS};
  localparam logic [7:0] MSK = {io_port_pkg::BANK_EVENT, io_port_pkg::IDX_MASK};

  io_port_pad_config dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .pad(pad), .irq(irq));
  board_model board (.clock(clock), .pad(pad), .extEn(extEn), .extVal(extVal),
    .pinIn(pinIn));

  // Clock of 8 ns
  always #4 clock = ~clock;

  // Word index of a port register: bank and offset 7 + port slot
  function automatic logic [7:0] rix(input logic [3:0] bank, input int p);
    return {bank, 4'(7 + p)};
  endfunction : rix

  // Implemented bits of a port slot
  function automatic logic [7:0] pm(input int p);
    return (p == 1) ? io_port_pkg::MASK_P8 : (p == 5) ? io_port_pkg::MASK_PC : 8'hFF;
  endfunction : pm

  // One APB transfer; waits for pready with a bound
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic readChk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0000_0000);
    check(48'(rd), 48'(exp));
  endtask : readChk

  // Let the write land on the pads
  task automatic settle;
    @(posedge clock);
    #1;
  endtask : settle

  task automatic summarize;
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #1;
    check(pad.oe, 48'h0000_0000_0000);
    for (int p = 0; p < 6; p++) begin
      readChk(rix(io_port_pkg::BANK_DIR, p), 32'(pm(p) | ((p == 5) ? 8'hF0 : 8'h00)));
      readChk(rix(io_port_pkg::BANK_PULL, p), 32'h0000_0000);
      xfer(1'b1, rix(io_port_pkg::BANK_PULL, p), 32'hFFFF_FFFF);
      readChk(rix(io_port_pkg::BANK_PULL, p), 32'(pm(p)));
      xfer(1'b1, rix(io_port_pkg::BANK_PULL, p), 32'h0000_0000);
      if (p < 5) begin
        xfer(1'b1, rix(io_port_pkg::BANK_DRAIN, p), 32'hFFFF_FFFF);
        readChk(rix(io_port_pkg::BANK_DRAIN, p), 32'(pm(p)));
        xfer(1'b1, rix(io_port_pkg::BANK_DRAIN, p), 32'h0000_0000);
      end
    end
    $display("register map test done");
    // Port 9 push-pull output, then open drain
    xfer(1'b1, rix(io_port_pkg::BANK_DATA, 2), 32'h0000_005A);
    xfer(1'b1, rix(io_port_pkg::BANK_DIR, 2), 32'h0000_0000);
    settle();
    check(48'(pad.oe[2]), 48'h0000_0000_00FF);
    check(48'(pad.out[2]), 48'h0000_0000_005A);
    readChk(rix(io_port_pkg::BANK_DATA, 2), 32'h0000_005A);
    xfer(1'b1, rix(io_port_pkg::BANK_DRAIN, 2), 32'h0000_00FF);
    settle();
    check(48'(pad.oe[2]), 48'h0000_0000_00A5);
    check(48'(pad.out[2]), 48'h0000_0000_0000);
    // Port A inputs read the board level, then pull-ups on released pins
    extVal[3] <= 8'hC3;
    readChk(rix(io_port_pkg::BANK_DATA, 3), 32'h0000_00C3);
    // Board lets go of bits 5..2, which then only the pull-ups hold high
    extEn[3] <= 8'hC3;
    // Pull-ups on bits 5..2, set by the pull register alone whatever the pin direction
    xfer(1'b1, rix(io_port_pkg::BANK_PULL, 3), 32'h0000_003C);
    settle();
    check(48'(pad.pullEn[3]), 48'h0000_0000_003C);
    readChk(rix(io_port_pkg::BANK_DATA, 3), 32'h0000_00FF);
    check(48'(rd & 32'h0000_003C), 48'h0000_0000_003C);
    extEn[3] <= 8'hFF;
    // Port C low nibble as outputs
    xfer(1'b1, {io_port_pkg::BANK_DRAIN, io_port_pkg::IDX_PORTC}, 32'h0000_0005);
    xfer(1'b1, rix(io_port_pkg::BANK_DIR, 5), 32'h0000_00F0);
    readChk({io_port_pkg::BANK_DRAIN, io_port_pkg::IDX_PORTC}, 32'h0000_00F5);
    check(48'(err), 48'h0000_0000_0000);
    check(48'(pad.oe[5][3:0]), 48'h0000_0000_000F);
    check(48'(pad.out[5][3:0]), 48'h0000_0000_0005);
    $display("pad drive test done");
    // Input-change events; steady pins through release raise none
    readChk(STAT, 32'h0000_0000);
    readChk(STAT, 32'h0000_0000);
    xfer(1'b1, MSK, 32'h0000_03FF);
    for (int i = 0; i < 10; i++) begin
      s = (i < 4) ? 0 : (i < 6) ? 1 : 4;
      b = (i < 4) ? i + 4 : (i < 6) ? i - 2 : i - 6;
      extVal[s][b] <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      check(48'(irq), 48'h0000_0000_0001);
      readChk(STAT, 32'h0000_0001 << i);
      #1;
      check(48'(irq), 48'h0000_0000_0000);
      extVal[s][b] <= 1'b1;
      repeat (3) @(posedge clock);
      readChk(STAT, 32'h0000_0001 << i);
    end
    // Unwatched pin, then a masked event
    extVal[0][0] <= 1'b0;
    repeat (3) @(posedge clock);
    readChk(STAT, 32'h0000_0000);
    xfer(1'b1, MSK, 32'h0000_0000);
    extVal[4][0] <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(48'(irq), 48'h0000_0000_0000);
    readChk(STAT, 32'h0000_0040);
    $display("input change test done");
    // Unmapped place is refused
    xfer(1'b1, 8'h30, 32'hFFFF_FFFF);
    check(48'(err), 48'h0000_0000_0001);
    readChk(8'h30, 32'h0000_0000);
    check(48'(err), 48'h0000_0000_0001);
    $display("unmapped access test done");
    summarize();
  end

  // Watchdog against a hang
  initial begin
    #100_000;
    mismatches++;
    summarize();
  end
endmodule : test_io_port_pad_config
